// [sim/fbci_flash_model.sv]
// Behavioural flash device on the far side of the host
`timescale 1ns/1ns
module fbci_flash_model #(parameter logic [7:0] MAKER_ID = 8'h5A, PART_ID = 8'h3C) ( // Codes are arbitrary
   input  wire logic [19:0] a,
   input  wire logic [14:0] d,
   input  wire logic        lane,
   input  wire logic        ce1_n,
   input  wire logic        ce2_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic        word,
   input  wire logic        deep_n,
   input  wire logic        hv,
   output logic      [14:0] q,
   output logic             lane_q,
   output logic             rdy
);
   logic [1:0]  st = 2'h0;
   logic [7:0]  code = 8'h00;
   logic        busy = 1'h0, ers = 1'h0, sus = 1'h0;
   logic [1:0]  prot = 2'h0;
   logic [7:0]  idv;
   logic [15:0] rv, bv, ld;
   logic [19:0] la;
   int          nwr = 0;
   // Only top and bottom sectors carry a protect bit, so A19 alone picks it
   assign idv = a[1] ? (prot[a[19]] ? MAKER_ID : 8'h00) : (a[0] ? PART_ID : MAKER_ID);
   // Codes, then status after an operation, else an address-shaped pattern so stale data never matches
   assign rv  = (code == 8'h90 || hv) ? {8'h00, idv}
              : (code == 8'hA0 || code == 8'h10 || code == 8'h30 || code == 8'h70) ? {8'h00, !busy, 7'h00}
              : a[15:0] ^ 16'h3C3C;
   assign bv = word ? rv : {8'h00, lane ? rv[15:8] : rv[7:0]};
   // Released pins show the inverse, never a held value
   assign {lane_q, q} = (!ce1_n && !ce2_n && deep_n && !oe_n && we_n) ? bv : ~bv;
   assign rdy = !busy || !deep_n;
   // Unlock decoder; any unexpected cycle restarts it
   always @(posedge we_n) if (!ce1_n && !ce2_n && deep_n && oe_n) begin
      nwr <= nwr + 1;
      la  <= a;
      ld  <= {lane, d};
      // A running program takes no command at all, read/reset included
      if (st == 2'h0 || (busy && !ers))
         st <= (!(busy && !ers) && a[14:0] == 15'h5555 && d[7:0] == 8'hAA) ? 2'h1 : 2'h0;
      else if (st == 2'h1)
         st <= (a[14:0] == 15'h2AAA && d[7:0] == 8'h55) ? 2'h2 : 2'h0;
      else if (st == 2'h2) begin
         // A running erase lets only status read and suspend through
         if (!busy || d[7:0] == 8'h70 || d[7:0] == 8'hB0) code <= d[7:0];
         if (busy && d[7:0] == 8'hB0) {busy, sus} <= 2'h1;
         if (sus && d[7:0] == 8'hD0) begin
            {busy, sus} <= 2'h2;
            busy <= #2000 1'h0;
         end
         if (!busy && code == 8'h80 && (d[7:0] == 8'h10 || d[7:0] == 8'h30)) begin
            {busy, ers} <= 2'h3;
            busy <= #4000 1'h0;
         end
         if (!busy && code == 8'h60 && (d[7:0] == 8'h20 || d[7:0] == 8'h40)) begin
            prot[a[19]] <= (d[7:0] == 8'h20);
         end
         st   <= (!busy && d[7:0] == 8'hA0) ? 2'h3 : 2'h0;
      end else begin
         st   <= 2'h0;
         {busy, ers} <= 2'h2;
         busy <= #400 1'h0;
      end
   end
endmodule

// [sim/tb_flash_bus_command_interface.sv]
// Self-checking bench driving the flash command host through its registers
`timescale 1ns/1ns
module tb_flash_bus_command_interface;
   import fbci_pkg::*;
   logic        clk = 1'h0, rst = 1'h1, wr_s = 1'h0, rd_s = 1'h0;
   logic [7:0]  ad = 8'h00;
   logic [31:0] wd = 32'h0000_0000, rdat, got;
   logic [19:0] fa;
   logic [14:0] dqo, dqi;
   logic        lo, li, c1, c2, oe, we, wm, dn, rdy, hv;
   logic [7:0]  op_tab[5] = '{8'h06, 8'h07, 8'h09, 8'h0D, 8'h0E};
   logic [7:0]  code_tab[5] = '{8'hB0, 8'hD0, 8'h50, 8'hC0, 8'hE0};
   int          miscompares = 0, check_count = 0, i;
   always #10 clk = ~clk;
   fbci_host #(.PULSE_N(3)) u_fbci_host (.clk(clk), .rst(rst), .reg_addr(ad), .reg_wdata(wd), .reg_wr(wr_s),
      .reg_rd(rd_s), .reg_rdata(rdat), .flash_addr(fa), .flash_dq_i(dqi), .flash_dq_o(dqo), .flash_dq_oe(),
      .byte_lane_select_i(li), .byte_lane_select_o(lo), .byte_lane_select_oe(), .chip_select_first_n(c1),
      .chip_select_second_n(c2), .flash_oe_n(oe), .flash_we_n(we), .flash_word_mode(wm), .deep_sleep_n(dn),
      .id_high_voltage(hv), .ready_busy_in(rdy));
   fbci_flash_model u_fbci_flash_model (.a(fa), .d(dqo), .lane(lo), .ce1_n(c1), .ce2_n(c2), .oe_n(oe),
      .we_n(we), .word(wm), .deep_n(dn), .hv(hv), .q(dqi), .lane_q(li), .rdy(rdy));
   // One-cycle register write
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk) {wr_s, ad, wd} <= {1'h1, a, d};
      @(posedge clk) wr_s <= 1'h0;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      check_count++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clk) {rd_s, ad} <= {1'h1, a};
      @(posedge clk) rd_s <= 1'h0;
      #1 got = rdat;
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Start a sequence and poll done under a bound, then clear the sticky bits
   task automatic run(input logic [7:0] op);
      int n;
      got = 32'h0000_0000;
      wr(REG_CMD, {24'h0, op});
      for (n = 0; n < 60 && got[STS_DONE] !== 1'h1; n++)
         rd(REG_STATUS);
      if (n == 60) begin
         miscompares++;
         tally_and_finish();
      end
      wr(REG_STATUS, 32'h0000_000C);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'h0;
      rd(REG_CONFIG);
      chk("config", 32'h0000_0002, got);
      rd(8'h20);
      chk("unmapped", 32'h0000_0000, got);
      wr(REG_ADDR, 32'h0001_2346);
      run(OP_ARRAY_READ);
      rd(REG_RDATA);
      chk("array", 32'h0000_1F7A, got);
      wr(REG_ADDR, 32'h0000_0001);
      run(OP_ID_READ);
      rd(REG_RDATA);
      chk("part id", 32'h0000_003C, got);
      run(OP_READ_RESET);
      rd(REG_RDATA);
      chk("array again", 32'h0000_3C3D, got);
      wr(REG_WDATA, 32'h0000_BEEF);
      wr(REG_ADDR, 32'h0008_0010);
      run(OP_PROGRAM);
      chk("prog data", 32'h0000_BEEF, u_fbci_flash_model.ld);
      chk("prog addr", 32'h0008_0010, u_fbci_flash_model.la);
      rd(REG_STATUS);
      chk("busy pin", 32'h0000_0000, got[1]);
      repeat (30) @(posedge clk);
      rd(REG_STATUS);
      chk("ready pin", 32'h0000_0001, got[1]);
      run(OP_ARRAY_READ);
      rd(REG_RDATA);
      chk("status after prog", 32'h0000_0080, got);
      // Short sequences, one of each code
      for (i = 0; i < 5; i++) begin
         run(op_tab[i]);
         chk("short code", {24'h0, code_tab[i]}, u_fbci_flash_model.code);
      end
      chk("writes", 32'h0000_0019, u_fbci_flash_model.nwr);
      wr(REG_CONFIG, 32'h0000_0003);
      wr(REG_ADDR, 32'h0000_0005);
      run(OP_ARRAY_READ);
      rd(REG_RDATA);
      chk("byte lane", 32'h0000_003C, got);
      wr(REG_CONFIG, 32'h0000_0000);
      wr(REG_CMD, {28'h0, OP_PROGRAM});
      rd(REG_STATUS);
      chk("refused", 32'h0000_0001, got[STS_REFUSED]);
      chk("no writes", 32'h0000_0019, u_fbci_flash_model.nwr);
      // High voltage on A9 gives the maker code with no command
      wr(REG_CONFIG, 32'h0000_0006);
      wr(REG_ADDR, 32'h0000_0000);
      run(OP_ARRAY_READ);
      rd(REG_RDATA);
      chk("hv maker", 32'h0000_005A, got);
      wr(REG_CONFIG, 32'h0000_0002);
      // Protect, then unprotect the top sector, verifying each
      wr(REG_ADDR, 32'h000F_0002);
      run(OP_PROTECT);
      run(OP_VERIFY_PROT);
      rd(REG_RDATA);
      chk("protected", 32'h0000_005A, got);
      run(OP_UNPROTECT);
      run(OP_VERIFY_PROT);
      rd(REG_RDATA);
      chk("unprotected", 32'h0000_0000, got);
      // Sector erase: read/reset ignored, suspend frees ready, resume and status read go through
      run(OP_SECT_ERASE);
      chk("erase addr", 32'h000F_0002, u_fbci_flash_model.la);
      rd(REG_STATUS);
      chk("erase busy", 32'h0000_0000, got[1]);
      run(OP_READ_RESET);
      chk("reset ignored", 32'h0000_0030, u_fbci_flash_model.code);
      run(OP_SUSPEND);
      rd(REG_STATUS);
      chk("suspended", 32'h0000_0001, got[1]);
      run(OP_RESUME);
      run(OP_READ_STATUS);
      chk("status code", 32'h0000_0070, u_fbci_flash_model.code);
      rd(REG_RDATA);
      chk("status busy", 32'h0000_0000, got);
      repeat (120) @(posedge clk);
      run(OP_ARRAY_READ);
      rd(REG_RDATA);
      chk("status ready", 32'h0000_0080, got);
      run(OP_CHIP_ERASE);
      chk("chip erase", 32'h0000_0010, u_fbci_flash_model.code);
      tally_and_finish();
   end
endmodule

// [src/fbci_bus_cycle.sv]
// One asynchronous flash bus cycle: setup, strobe pulse, hold
`timescale 1ns/1ns
module fbci_bus_cycle
   import fbci_pkg::*;
#(
   parameter int SETUP_N = SETUP_CYC,
   parameter int PULSE_N = PULSE_CYC,
   parameter int HOLD_N  = HOLD_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        start,
   input  wire fbci_step_t  step,
   input  wire logic        byte_mode,
   input  wire logic [14:0] dq_i,
   input  wire logic        lane_i,
   output logic [19:0]      flash_addr,
   output logic [14:0]      dq_o,
   output logic [14:0]      dq_oe,
   output logic             lane_o,
   output logic             lane_oe,
   output logic             ce_n,
   output logic             oe_n,
   output logic             we_n,
   output logic             done,
   output logic [15:0]      rdata
);
   typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_PULSE, PH_HOLD} fbci_phase_t;
   fbci_phase_t ph_r;
   logic [7:0]  cnt_r;
   logic        rd_r;
   logic [14:0] dq_s1_r, dq_s2_r;
   logic        lane_s1_r, lane_s2_r;
   logic [7:0]  we_low_r;

   // Pin inputs pass two flops; the strobe must outlast access time plus this lag
   always_ff @(posedge clk) begin
      dq_s1_r   <= dq_i;
      dq_s2_r   <= dq_s1_r;
      lane_s1_r <= lane_i;
      lane_s2_r <= lane_s1_r;
   end

   // Phase sequencing; strobes are registered so the pins never glitch
   always_ff @(posedge clk) begin
      done <= 1'b0;
      if (rst) begin
         ph_r <= PH_IDLE;
         cnt_r <= '0;
         rd_r <= 1'b1;
         ce_n <= 1'b1;
         oe_n <= 1'b1;
         we_n <= 1'b1;
         flash_addr <= '0;
         dq_o <= '0;
         dq_oe <= '0;
         lane_o <= 1'b0;
         lane_oe <= 1'b0;
         rdata <= '0;
      end else begin
         unique case (ph_r)
            PH_IDLE: if (start) begin
               ph_r <= PH_SETUP;
               cnt_r <= 8'(SETUP_N - 1);
               rd_r <= step.rd;
               ce_n <= 1'b0;
               flash_addr <= step.addr;
               dq_o <= step.data[14:0];
               // Byte mode: pin 15 is the lane address, upper lane floats
               lane_o <= byte_mode ? step.lane : step.data[15];
               lane_oe <= byte_mode | ~step.rd;
               dq_oe <= step.rd ? 15'h0000 : (byte_mode ? 15'h00FF : 15'h7FFF);
            end
            PH_SETUP: if (cnt_r == 8'h00) begin
               ph_r <= PH_PULSE;
               cnt_r <= 8'(PULSE_N - 1);
               we_n <= rd_r;
               oe_n <= ~rd_r;
            end else begin
               cnt_r <= cnt_r - 8'h01;
            end
            PH_PULSE: if (cnt_r == 8'h00) begin
               ph_r <= PH_HOLD;
               cnt_r <= 8'(HOLD_N - 1);
               we_n <= 1'b1;
               oe_n <= 1'b1;
               if (rd_r) begin
                  rdata <= byte_mode ? {8'h00, dq_s2_r[7:0]} : {lane_s2_r, dq_s2_r};
               end
            end else begin
               cnt_r <= cnt_r - 8'h01;
            end
            PH_HOLD: if (cnt_r == 8'h00) begin
               ph_r <= PH_IDLE;
               ce_n <= 1'b1;
               dq_oe <= '0;
               lane_oe <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt_r <= cnt_r - 8'h01;
            end
         endcase
      end
   end

   // Helper: length of the write strobe
   always_ff @(posedge clk) begin
      if (rst || we_n) we_low_r <= '0;
      else we_low_r <= we_low_r + 8'h01;
   end

   a_write_strobe_ok: assert property (@(posedge clk) disable iff (rst) !we_n |-> !ce_n && oe_n)
      else $error("write strobe without select or with output enable");
   a_write_pulse_len: assert property (@(posedge clk) disable iff (rst)
      $rose(we_n) |-> we_low_r == 8'(PULSE_N))
      else $error("write strobe length wrong");
   a_write_data_on: assert property (@(posedge clk) disable iff (rst) !we_n |-> dq_oe[0] && lane_oe)
      else $error("write strobe without data driven");
   // While the flash drives the bus the host must let go, except the lane address in byte mode
   a_read_bus_free: assert property (@(posedge clk) disable iff (rst)
      !oe_n |-> dq_oe == '0 && lane_oe == byte_mode)
      else $error("host drives data while flash outputs");
endmodule

// [src/fbci_host.sv]
// Host controller that issues unlock command sequences to a parallel NOR flash
//
// What this block does
// - Every sequence except array read opens with AA to 5555 then 55 to 2AAA.
// - Third write to 5555 carries the command code for the operation.
// - Erase adds AA/55 unlock, then 10 to 5555 or 30 to sector.
// - Sleep and abort are three-cycle sequences with C0 or E0.
// - Host writes with selects low, output enable high, write strobe pulsed.
`timescale 1ns/1ns
module fbci_host
   import fbci_pkg::*;
#(
   parameter int SETUP_N = SETUP_CYC,
   parameter int PULSE_N = PULSE_CYC,
   parameter int HOLD_N  = HOLD_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   output logic [19:0]      flash_addr,
   input  wire logic [14:0] flash_dq_i,
   output logic [14:0]      flash_dq_o,
   output logic [14:0]      flash_dq_oe,
   input  wire logic        byte_lane_select_i,
   output logic             byte_lane_select_o,
   output logic             byte_lane_select_oe,
   output logic             chip_select_first_n,
   output logic             chip_select_second_n,
   output logic             flash_oe_n,
   output logic             flash_we_n,
   output logic             flash_word_mode,
   output logic             deep_sleep_n,
   output logic             id_high_voltage,
   input  wire logic        ready_busy_in
);
   typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} fbci_state_t;
   fbci_state_t state_r;
   logic [3:0]  op_r;
   logic [2:0]  idx_r;
   logic [20:0] addr_r;
   logic [15:0] wdata_r;
   logic [15:0] rdata_r;
   logic [2:0]  cfg_r;
   logic        done_r, refused_r;
   logic        rb_s1_r, rb_s2_r;
   logic        start, cyc_done, ce_n, cmd_wr, cmd_ok;
   logic [15:0] cyc_rdata;
   logic [19:0] tgt;
   logic        tgt_lane;
   fbci_step_t  step;

   // Bus cycles per sequence
   function automatic logic [2:0] seq_len(input logic [3:0] op);
      unique case (op)
         OP_ARRAY_READ: return LEN_SINGLE;
         OP_SUSPEND, OP_RESUME, OP_CLR_STATUS, OP_SLEEP, OP_ABORT: return LEN_SHORT;
         OP_CHIP_ERASE, OP_SECT_ERASE, OP_PROTECT, OP_UNPROTECT: return LEN_LONG;
         default: return LEN_MID;
      endcase
   endfunction

   // Command code of the third write
   function automatic logic [7:0] third_code(input logic [3:0] op);
      unique case (op)
         OP_READ_RESET: return CODE_READ_RESET;
         OP_ID_READ, OP_VERIFY_PROT: return CODE_ID_READ;
         OP_PROGRAM: return CODE_PROGRAM;
         OP_CHIP_ERASE, OP_SECT_ERASE: return CODE_ERASE_SETUP;
         OP_SUSPEND: return CODE_SUSPEND;
         OP_RESUME: return CODE_RESUME;
         OP_READ_STATUS: return CODE_READ_STATUS;
         OP_CLR_STATUS: return CODE_CLR_STATUS;
         OP_PROTECT, OP_UNPROTECT: return CODE_PROT_SETUP;
         OP_SLEEP: return CODE_SLEEP;
         default: return CODE_ABORT;
      endcase
   endfunction

   // Command code of the sixth write
   function automatic logic [7:0] sixth_code(input logic [3:0] op);
      unique case (op)
         OP_CHIP_ERASE: return CODE_CHIP_ERASE;
         OP_SECT_ERASE: return CODE_SECT_ERASE;
         OP_PROTECT: return CODE_PROTECT;
         default: return CODE_UNPROTECT;
      endcase
   endfunction

   // Address and data of bus cycle idx of a sequence
   function automatic fbci_step_t seq_step(input logic [3:0] op, input logic [2:0] idx, input logic [19:0] ta,
                                           input logic tl, input logic [15:0] wd);
      fbci_step_t s;
      // Command cycles drive zero on the upper data byte, and on address bits 15 to 19 except the sector-addressed sixth write
      s.rd = 1'b0;
      s.addr = UNLOCK_ADDR_1;
      s.lane = 1'b0;
      s.data = 16'(UNLOCK_DATA_1);
      if (op == OP_ARRAY_READ) begin
         s.rd = 1'b1;
         s.addr = ta;
         s.lane = tl;
      end else begin
         unique case (idx)
            3'h1: begin
               s.addr = UNLOCK_ADDR_2;
               s.data = 16'(UNLOCK_DATA_2);
            end
            3'h2: s.data = 16'(third_code(op));
            3'h3: if (seq_len(op) != LEN_LONG) begin
               // Fourth cycle: program data, or a read of array, codes or status
               s.rd = (op != OP_PROGRAM);
               s.addr = ta;
               s.lane = tl;
               s.data = wd;
            end
            3'h4: begin
               s.addr = UNLOCK_ADDR_2;
               s.data = 16'(UNLOCK_DATA_2);
            end
            3'h5: begin
               s.addr = (op == OP_CHIP_ERASE) ? UNLOCK_ADDR_1 : ta;
               s.data = 16'(sixth_code(op));
            end
            default: s.addr = UNLOCK_ADDR_1;
         endcase
      end
      return s;
   endfunction

   // Target address: in byte mode bit 0 of the address register is the lane
   assign tgt      = cfg_r[CFG_BYTE_MODE] ? addr_r[20:1] : addr_r[19:0];
   assign tgt_lane = cfg_r[CFG_BYTE_MODE] & addr_r[0];
   assign step     = seq_step(op_r, idx_r, tgt, tgt_lane, wdata_r);
   assign start    = (state_r == ST_ISSUE);
   assign cmd_wr   = reg_wr && (reg_addr == REG_CMD);
   // No command while the flash sleeps, while busy or with an unknown opcode
   assign cmd_ok   = (state_r == ST_IDLE) && cfg_r[CFG_DEEP_N] && (reg_wdata[3:0] <= OP_LAST);

   fbci_bus_cycle #(
      .SETUP_N (SETUP_N),
      .PULSE_N (PULSE_N),
      .HOLD_N  (HOLD_N)
   ) u_cycle (
      .clk        (clk),
      .rst        (rst),
      .start      (start),
      .step       (step),
      .byte_mode  (cfg_r[CFG_BYTE_MODE]),
      .dq_i       (flash_dq_i),
      .lane_i     (byte_lane_select_i),
      .flash_addr (flash_addr),
      .dq_o       (flash_dq_o),
      .dq_oe      (flash_dq_oe),
      .lane_o     (byte_lane_select_o),
      .lane_oe    (byte_lane_select_oe),
      .ce_n       (ce_n),
      .oe_n       (flash_oe_n),
      .we_n       (flash_we_n),
      .done       (cyc_done),
      .rdata      (cyc_rdata)
   );

   // Both selects move together so the device sees one select edge
   assign chip_select_first_n  = ce_n;
   assign chip_select_second_n = ce_n;
   assign flash_word_mode      = ~cfg_r[CFG_BYTE_MODE];
   assign deep_sleep_n         = cfg_r[CFG_DEEP_N];
   assign id_high_voltage      = cfg_r[CFG_ID_HV];

   // Ready/busy comes from an open-drain pin: two flops first
   always_ff @(posedge clk) begin
      rb_s1_r <= ready_busy_in;
      rb_s2_r <= rb_s1_r;
   end

   // Sequencer: one bus cycle after another until the sequence is complete
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= ST_IDLE;
         op_r <= OP_ARRAY_READ;
         idx_r <= '0;
      end else begin
         unique case (state_r)
            ST_IDLE: if (cmd_wr && cmd_ok) begin
               op_r <= reg_wdata[3:0];
               idx_r <= '0;
               state_r <= ST_ISSUE;
            end
            ST_ISSUE: state_r <= ST_WAIT;
            ST_WAIT: if (cyc_done) begin
               // Never cut short: a partial sequence would leave the device mid-unlock
               if (idx_r == seq_len(op_r) - 3'h1) begin
                  state_r <= ST_IDLE;
               end else begin
                  idx_r <= idx_r + 3'h1;
                  state_r <= ST_ISSUE;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Software registers; a hardware set beats a clear in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         addr_r <= '0;
         wdata_r <= '0;
         cfg_r <= CFG_RESET;
         done_r <= 1'b0;
         refused_r <= 1'b0;
         rdata_r <= '0;
      end else begin
         if (reg_wr && reg_addr == REG_ADDR) addr_r <= reg_wdata[20:0];
         if (reg_wr && reg_addr == REG_WDATA) wdata_r <= reg_wdata[15:0];
         if (reg_wr && reg_addr == REG_CONFIG) cfg_r <= reg_wdata[2:0];
         if (cyc_done && step.rd) rdata_r <= cyc_rdata;
         if (state_r == ST_WAIT && cyc_done && idx_r == seq_len(op_r) - 3'h1) done_r <= 1'b1;
         else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[STS_DONE]) done_r <= 1'b0;
         if (cmd_wr && !cmd_ok) refused_r <= 1'b1;
         else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[STS_REFUSED]) refused_r <= 1'b0;
      end
   end

   // Read data stand in the cycle after the strobe; unmapped offsets read zero
   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         unique case (reg_addr)
            REG_CMD: reg_rdata <= 32'(op_r);
            REG_ADDR: reg_rdata <= 32'(addr_r);
            REG_WDATA: reg_rdata <= 32'(wdata_r);
            REG_RDATA: reg_rdata <= 32'(rdata_r);
            REG_CONFIG: reg_rdata <= 32'(cfg_r);
            REG_STATUS: reg_rdata <= 32'({refused_r, done_r, rb_s2_r, state_r != ST_IDLE});
            default: reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

   // Helper: bus cycles started in the current sequence
   logic [2:0] starts_r;
   always_ff @(posedge clk) begin
      if (rst || (state_r == ST_IDLE)) starts_r <= '0;
      else if (start) starts_r <= starts_r + 3'h1;
   end

   a_unlock_first: assert property (@(posedge clk) disable iff (rst)
      start && idx_r == 3'h0 && op_r != OP_ARRAY_READ |-> step.addr == UNLOCK_ADDR_1 && step.data == 16'(UNLOCK_DATA_1))
      else $error("first unlock write wrong");
   a_unlock_second: assert property (@(posedge clk) disable iff (rst)
      start && idx_r == 3'h1 |-> !step.rd && step.addr == UNLOCK_ADDR_2 && step.data == 16'(UNLOCK_DATA_2))
      else $error("second unlock write wrong");
   a_program_code: assert property (@(posedge clk) disable iff (rst)
      start && idx_r == 3'h2 && op_r == OP_PROGRAM |-> step.addr == UNLOCK_ADDR_1 && step.data == 16'(CODE_PROGRAM))
      else $error("program code wrong");
   a_seq_count: assert property (@(posedge clk) disable iff (rst)
      state_r == ST_WAIT ##1 state_r == ST_IDLE |-> $past(starts_r) == seq_len(op_r))
      else $error("sequence length wrong");
   a_erase_last: assert property (@(posedge clk) disable iff (rst)
      start && idx_r == 3'h5 && op_r == OP_CHIP_ERASE |-> step.addr == UNLOCK_ADDR_1 && step.data == 16'(CODE_CHIP_ERASE))
      else $error("chip erase write wrong");
   a_protect_last: assert property (@(posedge clk) disable iff (rst)
      start && idx_r == 3'h5 && op_r == OP_PROTECT |-> step.addr == tgt && step.data == 16'(CODE_PROTECT))
      else $error("sector protect write wrong");
   a_sleep_short: assert property (@(posedge clk) disable iff (rst)
      start && idx_r == 3'h2 && op_r == OP_SLEEP |-> step.data == 16'(CODE_SLEEP) ##[1:300] state_r == ST_IDLE)
      else $error("sleep sequence wrong");
   a_sleep_refuse: assert property (@(posedge clk) disable iff (rst)
      cmd_wr && !cfg_r[CFG_DEEP_N] |=> state_r == ST_IDLE && refused_r)
      else $error("command issued during deep power-down");
   a_select_pair: assert property (@(posedge clk) disable iff (rst)
      $fell(flash_we_n) |-> !chip_select_first_n && !chip_select_second_n)
      else $error("write without both selects");

   c_program_done: cover property (@(posedge clk) disable iff (rst) op_r == OP_PROGRAM && $rose(done_r));
   c_chip_erase: cover property (@(posedge clk) disable iff (rst) op_r == OP_CHIP_ERASE && $rose(done_r));
   c_id_read: cover property (@(posedge clk) disable iff (rst) op_r == OP_ID_READ && cyc_done && step.rd);
   c_refused: cover property (@(posedge clk) disable iff (rst) $rose(refused_r));
endmodule

// [src/fbci_pkg.sv]
// Constants and types shared by the flash command host and its bus cycle engine
package fbci_pkg;
   // Clock and bus cycle timing (50 MHz)
   localparam int CLK_PERIOD_NS = 20;
   localparam int T_SETUP_NS    = 20;
   localparam int T_PULSE_NS    = 140;
   localparam int T_HOLD_NS     = 20;
   localparam int SETUP_RAW     = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_RAW     = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_RAW      = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_CYC     = (SETUP_RAW < 1) ? 1 : SETUP_RAW;
   localparam int PULSE_CYC     = (PULSE_RAW < 1) ? 1 : PULSE_RAW;
   localparam int HOLD_CYC      = (HOLD_RAW < 1) ? 1 : HOLD_RAW;
   // Unlock prefix and command codes
   localparam logic [19:0] UNLOCK_ADDR_1 = 20'h0_5555;
   localparam logic [19:0] UNLOCK_ADDR_2 = 20'h0_2AAA;
   localparam logic [7:0] UNLOCK_DATA_1  = 8'hAA;
   localparam logic [7:0] UNLOCK_DATA_2  = 8'h55;
   localparam logic [7:0] CODE_READ_RESET  = 8'hF0;
   localparam logic [7:0] CODE_ID_READ     = 8'h90;
   localparam logic [7:0] CODE_PROGRAM     = 8'hA0;
   localparam logic [7:0] CODE_ERASE_SETUP = 8'h80;
   localparam logic [7:0] CODE_SUSPEND     = 8'hB0;
   localparam logic [7:0] CODE_RESUME      = 8'hD0;
   localparam logic [7:0] CODE_READ_STATUS = 8'h70;
   localparam logic [7:0] CODE_CLR_STATUS  = 8'h50;
   localparam logic [7:0] CODE_PROT_SETUP  = 8'h60;
   localparam logic [7:0] CODE_SLEEP       = 8'hC0;
   localparam logic [7:0] CODE_ABORT       = 8'hE0;
   localparam logic [7:0] CODE_CHIP_ERASE  = 8'h10;
   localparam logic [7:0] CODE_SECT_ERASE  = 8'h30;
   localparam logic [7:0] CODE_PROTECT     = 8'h20;
   localparam logic [7:0] CODE_UNPROTECT   = 8'h40;
   // Software opcodes
   localparam logic [3:0] OP_ARRAY_READ  = 4'h0;
   localparam logic [3:0] OP_READ_RESET  = 4'h1;
   localparam logic [3:0] OP_ID_READ     = 4'h2;
   localparam logic [3:0] OP_PROGRAM     = 4'h3;
   localparam logic [3:0] OP_CHIP_ERASE  = 4'h4;
   localparam logic [3:0] OP_SECT_ERASE  = 4'h5;
   localparam logic [3:0] OP_SUSPEND     = 4'h6;
   localparam logic [3:0] OP_RESUME      = 4'h7;
   localparam logic [3:0] OP_READ_STATUS = 4'h8;
   localparam logic [3:0] OP_CLR_STATUS  = 4'h9;
   localparam logic [3:0] OP_PROTECT     = 4'hA;
   localparam logic [3:0] OP_UNPROTECT   = 4'hB;
   localparam logic [3:0] OP_VERIFY_PROT = 4'hC;
   localparam logic [3:0] OP_SLEEP       = 4'hD;
   localparam logic [3:0] OP_ABORT       = 4'hE;
   localparam logic [3:0] OP_LAST        = 4'hE;
   // Sequence lengths in bus cycles
   localparam logic [2:0] LEN_SINGLE = 3'h1;
   localparam logic [2:0] LEN_SHORT  = 3'h3;
   localparam logic [2:0] LEN_MID    = 3'h4;
   localparam logic [2:0] LEN_LONG   = 3'h6;
   // Register map and fields
   localparam logic [7:0] REG_CMD    = 8'h00;
   localparam logic [7:0] REG_ADDR   = 8'h04;
   localparam logic [7:0] REG_WDATA  = 8'h08;
   localparam logic [7:0] REG_RDATA  = 8'h0C;
   localparam logic [7:0] REG_CONFIG = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;
   localparam int CFG_BYTE_MODE   = 0;
   localparam int CFG_DEEP_N      = 1;
   localparam int CFG_ID_HV       = 2;
   localparam logic [2:0] CFG_RESET = 3'h2;
   localparam int STS_DONE    = 2;
   localparam int STS_REFUSED = 3;
   typedef struct packed {
      logic        rd;
      logic [19:0] addr;
      logic        lane;
      logic [15:0] data;
   } fbci_step_t;
endpackage
